// >>> rtl/rws_pkg.sv
// Contract
// - Only two reset sources exist: supply power-on reset and watchdog rollover.
// - Either reset returns every register to default and disables all interrupts; status instead takes the cause pattern.
// - Either reset clears the USB device address register to zero.
// - Either reset sets program and data stack pointers to 0x00.
// - Status register records the cause: power-on flag and watchdog flag bit 6.
// - After any reset the CPU fetches first from program address 0x0000.
// - Reset entry writes nothing to the program stack.
// - During power-on reset and semi-suspend only the CPU is held.
// - Power-on reset ends once supply is good and oscillator stable; timer starts.
// - Semi-suspend is 1 ms uninterruptible, then 95 ms more before execution.
// - Upstream bus reset during the 95 ms ends semi-suspend and starts execution.
// - Bus reset stays pending until enable bit 0 at 0x20 and global enable.
// - Supply drop reasserts power-on reset and repeats the whole sequence.
// - Any write to watchdog restart at 0x26 clears the watchdog counter.
// - Watchdog rolls over after at least 8 ms without clear; firmware restarts sooner.
// - Watchdog reset loads status with pattern 010X0001.
// - Watchdog reset holds 2 ms, then execution starts at 0x0000.
// - Watchdog reset clears device address, silencing USB transmission.
package rws_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  ADDR_USB_ADDR    = 8'h10;
	localparam logic [7:0]  ADDR_INT_EN      = 8'h20;
	localparam logic [7:0]  ADDR_WDT_RESTART = 8'h26;
	localparam logic [7:0]  ADDR_STATUS      = 8'hff;
	localparam int          STAT_RUN_BIT     = 0;
	localparam int          STAT_POR_BIT     = 4;
	localparam int          STAT_WDR_BIT     = 6;
	localparam int          INT_EN_BUSRST    = 0;
	localparam logic [7:0]  STAT_POR_VALUE   = 8'h11;
	localparam logic [7:0]  STAT_WDR_SET     = 8'h41;
	localparam logic [7:0]  STAT_WDR_KEEP    = 8'h10;
	localparam logic [7:0]  STAT_FLAG_MASK   = 8'h50;
	localparam logic [7:0]  REG_RESET        = 8'h00;
	localparam logic [13:0] PC_RESET         = 14'h0000;
	localparam logic [7:0]  SP_RESET         = 8'h00;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ      = 20_000_000;
	localparam int TICK_MS     = 1;
	localparam int TICK_CYC    = TICK_MS * (CLK_HZ / 1000);
	localparam int SS_LOCK_MS  = 1;
	localparam int SS_WAIT_MS  = 95;
	localparam int WDR_HOLD_MS = 2;
	localparam int WDT_MS      = 8;
	localparam int MSW         = 7;
	// ****************************************
	// Sequencer states
	// ****************************************
	typedef enum logic [4:0] {
		ST_POR  = 5'b00001,
		ST_LOCK = 5'b00010,
		ST_WAIT = 5'b00100,
		ST_WDR  = 5'b01000,
		ST_RUN  = 5'b10000
	} rws_state_t;
endpackage

// >>> rtl/rws_sync3.sv
`timescale 1ns/1ps
module rws_sync3 #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	// Pins in, filtered level out
	input  wire logic [W-1:0] pin,
	output      logic [W-1:0] level
);
	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
		logic [W-1:0] ff3;
		logic [W-1:0] lvl;
	} rws_sync_t;

	rws_sync_t q;
	rws_sync_t next_q;

	// A change counts only once stages two and three agree
	always_comb begin
		next_q     = q;
		next_q.ff1 = pin;
		next_q.ff2 = q.ff1;
		next_q.ff3 = q.ff2;
		next_q.lvl = (q.ff2 & q.ff3) | (q.lvl & (q.ff2 | q.ff3));
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			q <= next_q;
		end
	end

	assign level = q.lvl;
endmodule

// >>> rtl/rws_seq.sv
`timescale 1ns/1ps
module rws_seq
	import rws_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int LOCK_TICKS  = SS_LOCK_MS,
	parameter int WAIT_TICKS  = SS_WAIT_MS,
	parameter int WDR_TICKS   = WDR_HOLD_MS,
	parameter int WDT_TICKS   = WDT_MS
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Pins
	input  wire logic        supply_ok_pin,
	input  wire logic        osc_stable_pin,
	input  wire logic        usb_bus_reset_pin,
	// CPU side
	input  wire logic        gie_on,
	input  wire logic        irq_ack,
	output      logic        cpu_run,
	output      logic        cpu_start,
	output      logic        stack_wr_block,
	output      logic [13:0] pc_init,
	output      logic [7:0]  psp_init,
	output      logic [7:0]  dsp_init,
	output      logic        sys_rst_n,
	output      logic        bus_reset_irq,
	// USB side
	output      logic [7:0]  usb_dev_addr,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output      logic [7:0]  rdata
);
	localparam int DW = $clog2(TICK_CYCLES + 1);
	localparam logic [DW-1:0]  DIV_LAST  = DW'(TICK_CYCLES - 1);
	localparam logic [MSW-1:0] LOCK_LAST = MSW'(LOCK_TICKS - 1);
	localparam logic [MSW-1:0] WAIT_LAST = MSW'(WAIT_TICKS - 1);
	localparam logic [MSW-1:0] WDR_LAST  = MSW'(WDR_TICKS - 1);
	localparam logic [MSW-1:0] WDT_LAST  = MSW'(WDT_TICKS - 1);

	typedef struct packed {
		rws_state_t     st;
		logic [DW-1:0]  div;
		logic           tick;
		logic [MSW-1:0] ms;
		logic [7:0]     stat;
		logic [7:0]     int_en;
		logic [7:0]     usb_addr;
		logic [7:0]     rdata;
		logic           pend;
		logic           run;
		logic           start;
		logic           srst_n;
		logic           stk_blk;
		logic           irq;
		logic [13:0]    pc;
		logic [7:0]     program_stack_pointer;
		logic [7:0]     dsp;
	} rws_regs_t;

	rws_regs_t q;
	rws_regs_t next_q;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] pins_lvl;
	logic       sup;
	logic       osc;
	logic       usb_rst;

	rws_sync3 #(
		.W       (3),
		.RST_VAL (3'h0)
	) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.pin     ({usb_bus_reset_pin, osc_stable_pin, supply_ok_pin}),
		.level   (pins_lvl)
	);

	assign sup     = pins_lvl[0];
	assign osc     = pins_lvl[1];
	assign usb_rst = pins_lvl[2];

	logic wr_ok;
	logic wdt_kick;
	logic [7:0] stat_wr;

	assign wr_ok    = wr && (q.st == ST_RUN);
	assign wdt_kick = wr_ok && (addr == ADDR_WDT_RESTART);
	// Flags clear by writing one; other bits plain
	assign stat_wr  = (wdata & ~STAT_FLAG_MASK) | (q.stat & STAT_FLAG_MASK & ~wdata);

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		logic restart;
		restart      = 1'b0;
		next_q       = q;
		next_q.start = 1'b0;
		next_q.tick  = 1'b0;
		// Millisecond tick, one divider shared by all intervals
		if (q.div == DIV_LAST) begin
			next_q.div  = '0;
			next_q.tick = 1'b1;
		end else begin
			next_q.div = q.div + 1'b1;
		end
		unique case (q.st)
			ST_POR: begin
				if (sup && osc) begin
					next_q.st = ST_LOCK;
					restart   = 1'b1;
				end
			end
			ST_LOCK: begin
				// Bus reset deliberately ignored here
				if (q.tick) begin
					next_q.ms = q.ms + 1'b1;
					if (q.ms == LOCK_LAST) begin
						next_q.st = ST_WAIT;
						restart   = 1'b1;
					end
				end
			end
			ST_WAIT: begin
				if (usb_rst) begin
					next_q.st    = ST_RUN;
					next_q.start = 1'b1;
					next_q.pend  = 1'b1;
				end else if (q.tick) begin
					next_q.ms = q.ms + 1'b1;
					if (q.ms == WAIT_LAST) begin
						next_q.st    = ST_RUN;
						next_q.start = 1'b1;
					end
				end
			end
			ST_WDR: begin
				if (q.tick) begin
					next_q.ms = q.ms + 1'b1;
					if (q.ms == WDR_LAST) begin
						next_q.st    = ST_RUN;
						next_q.start = 1'b1;
					end
				end
			end
			ST_RUN: begin
				if (wdt_kick) begin
					restart = 1'b1;
				end else if (q.tick) begin
					next_q.ms = q.ms + 1'b1;
					// Divider restarts with each kick, so rollover is exactly 8 ticks
					if (q.ms == WDT_LAST) begin
						next_q.st   = ST_WDR;
						next_q.stat = (q.stat & STAT_WDR_KEEP) | STAT_WDR_SET;
						restart     = 1'b1;
					end
				end
			end
			default: begin
				next_q.st = ST_POR;
				restart   = 1'b1;
			end
		endcase
		// Watchdog counts afresh from the first run cycle
		if (next_q.start) begin
			restart = 1'b1;
		end
		// Supply loss overrides everything, sequence restarts
		if (!sup) begin
			next_q.st    = ST_POR;
			next_q.stat  = STAT_POR_VALUE;
			next_q.start = 1'b0;
			restart      = 1'b1;
		end
		if (restart) begin
			next_q.div  = '0;
			next_q.tick = 1'b0;
			next_q.ms   = '0;
		end
		// ****************************************
		// Registers, enable, address and pending held at default outside run
		// ****************************************
		// Reset entry in the same cycle beats a register write
		if (wr_ok && next_q.st == ST_RUN) begin
			unique case (addr)
				ADDR_INT_EN:   next_q.int_en   = wdata;
				ADDR_USB_ADDR: next_q.usb_addr = wdata;
				ADDR_STATUS:   next_q.stat     = stat_wr;
				default:       ;
			endcase
		end
		if (irq_ack) begin
			next_q.pend = 1'b0;
		end
		if (next_q.st != ST_RUN) begin
			next_q.int_en   = REG_RESET;
			next_q.usb_addr = REG_RESET;
			next_q.pend     = 1'b0;
		end
		// Early exit sets pending again so a same-cycle ack cannot lose it
		if (q.st == ST_WAIT && next_q.st == ST_RUN && usb_rst) begin
			next_q.pend = 1'b1;
		end
		next_q.rdata = 8'h00;
		if (rd) begin
			unique case (addr)
				ADDR_INT_EN:   next_q.rdata = q.int_en;
				ADDR_USB_ADDR: next_q.rdata = q.usb_addr;
				ADDR_STATUS:   next_q.rdata = q.stat;
				default:       next_q.rdata = 8'h00;
			endcase
		end
		// Oscillator and divider keep running, only the CPU waits
		next_q.run     = (next_q.st == ST_RUN);
		next_q.srst_n  = (next_q.st == ST_RUN);
		// Stack writes barred through reset and its first cycle
		next_q.stk_blk = !next_q.run || next_q.start;
		// Next run flag, so no request outlives reset entry
		next_q.irq     = q.pend && q.int_en[INT_EN_BUSRST] && gie_on && next_q.run;
		next_q.pc      = PC_RESET;
		next_q.program_stack_pointer     = SP_RESET;
		next_q.dsp     = SP_RESET;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q          <= '0;
			q.st       <= ST_POR;
			q.stat     <= STAT_POR_VALUE;
			q.stk_blk  <= 1'b1;
			q.pc       <= PC_RESET;
			q.program_stack_pointer      <= SP_RESET;
			q.dsp      <= SP_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign cpu_run        = q.run;
	assign cpu_start      = q.start;
	assign stack_wr_block = q.stk_blk;
	assign pc_init        = q.pc;
	assign psp_init       = q.program_stack_pointer;
	assign dsp_init       = q.dsp;
	assign sys_rst_n      = q.srst_n;
	assign bus_reset_irq  = q.irq;
	assign usb_dev_addr   = q.usb_addr;
	assign rdata          = q.rdata;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	a_lock_no_abort: assert property (
		q.st == ST_LOCK |=> !cpu_run
	) else $error("CPU started during locked semi-suspend");

	a_bus_abort: assert property (
		(q.st == ST_WAIT && usb_rst && sup) |=> (cpu_start && cpu_run && q.pend)
	) else $error("Bus reset did not end semi-suspend");

	a_pend_gated: assert property (
		(q.pend && !(q.int_en[INT_EN_BUSRST] && gie_on)) |=> !bus_reset_irq
	) else $error("Bus reset interrupt raised while not enabled");

	a_supply_drop: assert property (
		!sup |=> (q.st == ST_POR && !cpu_run && !sys_rst_n)
	) else $error("Supply loss did not reassert power-on reset");

	a_wdt_clear: assert property (
		(wdt_kick && sup) |=> (q.ms == '0 && q.st == ST_RUN)
	) else $error("Watchdog restart did not clear counter");

	a_wdt_roll: assert property (
		(q.st == ST_RUN && q.tick && q.ms == WDT_LAST && sup && !wdt_kick)
		|=> (q.st == ST_WDR && q.stat[STAT_WDR_BIT] && q.stat[STAT_RUN_BIT])
	) else $error("Watchdog rollover missed or wrong status");

	a_wdr_pattern: assert property (
		$rose(q.st == ST_WDR) |-> ((q.stat & ~STAT_WDR_KEEP) == STAT_WDR_SET)
	) else $error("Watchdog status pattern wrong");

	a_wdr_hold: assert property (
		(q.st == ST_WDR && q.tick && q.ms == WDR_LAST && sup) |=> (cpu_start && cpu_run)
	) else $error("Watchdog hold did not end on time");

	a_reset_clears: assert property (
		!cpu_run |-> (usb_dev_addr == REG_RESET && !sys_rst_n && !bus_reset_irq)
	) else $error("Registers not at default during reset");

	a_start_vector: assert property (
		cpu_start |-> (pc_init == PC_RESET && psp_init == SP_RESET
			&& dsp_init == SP_RESET && stack_wr_block)
	) else $error("Start without clean vector or stack");

	a_osc_gate: assert property (
		(q.st == ST_POR && !(sup && osc)) |=> q.st == ST_POR
	) else $error("Power-on reset ended without good supply and oscillator");

	a_stack_block: assert property (
		!cpu_run |-> stack_wr_block
	) else $error("Stack writes allowed during reset");

	a_int_off: assert property (
		!cpu_run |-> (q.int_en == REG_RESET && !q.pend)
	) else $error("Interrupt state kept during reset");

	a_start_fresh: assert property (
		cpu_start |-> (q.ms == '0 && q.div == '0)
	) else $error("Watchdog not fresh at start of execution");

	a_wdr_addr: assert property (
		$rose(q.st == ST_WDR) |-> usb_dev_addr == REG_RESET
	) else $error("Device address kept on watchdog reset");

	a_por_status: assert property (
		q.st == ST_POR |-> q.stat == STAT_POR_VALUE
	) else $error("Power-on status pattern wrong");

	a_wdt_early: assert property (
		(q.st == ST_RUN && sup && !(q.tick && q.ms == WDT_LAST)) |=> q.st == ST_RUN
	) else $error("Watchdog rolled over early");

	a_lock_len: assert property (
		(q.st == ST_LOCK && sup && !(q.tick && q.ms == LOCK_LAST)) |=> q.st == ST_LOCK
	) else $error("Locked semi-suspend ended early");

	a_wdr_len: assert property (
		(q.st == ST_WDR && sup && !(q.tick && q.ms == WDR_LAST)) |=> q.st == ST_WDR
	) else $error("Watchdog hold ended early");

	c_bus_abort: cover property (q.st == ST_WAIT ##1 q.st == ST_RUN && q.pend);
	c_wdt_roll:  cover property (q.st == ST_RUN ##1 q.st == ST_WDR);
	c_wait_end:  cover property (q.st == ST_WAIT ##1 cpu_start && !q.pend);
	c_supply:    cover property (q.st == ST_RUN ##1 q.st == ST_POR);
	c_wdr_end:   cover property (q.st == ST_WDR ##1 cpu_start);
endmodule

// >>> verif/rws_host_model.sv
`timescale 1ns/1ps
module rws_host_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	// Bench control
	input  wire logic       bus_reset_req,
	input  wire logic [3:0] ack_dly,
	// Sequencer side
	input  wire logic       bus_reset_irq,
	output      logic       usb_bus_reset_pin,
	output      logic       irq_ack
);
	logic [3:0] wait_cnt;

	// ****************
	// Upstream detector and handler
	// ****************
	// Level held for as long as the upstream port drives reset
	assign usb_bus_reset_pin = bus_reset_req;

	// Handler only acknowledges, never returns from reset
	// Ack comes late on purpose when ack_dly is large
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_ack  <= 1'b0;
			wait_cnt <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			if (bus_reset_irq && !irq_ack) begin
				if (wait_cnt == ack_dly) begin
					irq_ack  <= 1'b1;
					wait_cnt <= 4'h0;
				end else begin
					wait_cnt <= wait_cnt + 4'h1;
				end
			end else begin
				wait_cnt <= 4'h0;
			end
		end
	end
endmodule

// >>> verif/reset_and_watchdog_sequencer_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module reset_and_watchdog_sequencer_tb import rws_pkg::*;;
	localparam int T     = 20;
	localparam int LIMIT = 8000;
	typedef struct packed {logic w; logic [7:0] a; logic [7:0] v;} rws_row_t;
	// ****************
	// Signals
	// ****************
	logic        clk_sys = 1'b0;
	logic        nrst, supply_ok_pin, osc_stable_pin, usb_bus_reset_pin, gie_on, irq_ack;
	logic        cpu_run, cpu_start, stack_wr_block, sys_rst_n, bus_reset_irq, wr, rd;
	logic        bus_reset_req;
	logic [3:0]  ack_dly;
	logic [13:0] pc_init;
	logic [7:0]  psp_init, dsp_init, usb_dev_addr, addr, wdata, rdata, d;
	int          failures, checks, n;
	int          cyc = 0;
	// Writes each followed by a read, plus two plain reads; v is write data or expected read
	rws_row_t    rows[10] = '{
		'{1'b1, ADDR_USB_ADDR, 8'h5a}, '{1'b0, ADDR_USB_ADDR, 8'h5a},
		'{1'b1, ADDR_INT_EN, 8'h01}, '{1'b0, ADDR_INT_EN, 8'h01},
		'{1'b1, ADDR_WDT_RESTART, 8'ha5}, '{1'b0, ADDR_WDT_RESTART, 8'h00},
		'{1'b0, 8'h33, 8'h00}, '{1'b0, ADDR_STATUS, STAT_POR_VALUE},
		'{1'b1, ADDR_STATUS, 8'h11}, '{1'b0, ADDR_STATUS, 8'h01}};

	always #25 clk_sys = ~clk_sys;

	rws_seq #(.TICK_CYCLES(T)) dut (.clk_sys(clk_sys), .nrst(nrst),
		.supply_ok_pin(supply_ok_pin), .osc_stable_pin(osc_stable_pin),
		.usb_bus_reset_pin(usb_bus_reset_pin), .gie_on(gie_on), .irq_ack(irq_ack),
		.cpu_run(cpu_run), .cpu_start(cpu_start), .stack_wr_block(stack_wr_block),
		.pc_init(pc_init), .psp_init(psp_init), .dsp_init(dsp_init),
		.sys_rst_n(sys_rst_n), .bus_reset_irq(bus_reset_irq),
		.usb_dev_addr(usb_dev_addr), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));

	rws_host_model host (.clk_sys(clk_sys), .nrst(nrst), .bus_reset_req(bus_reset_req),
		.ack_dly(ack_dly), .bus_reset_irq(bus_reset_irq),
		.usb_bus_reset_pin(usb_bus_reset_pin), .irq_ack(irq_ack));

	// ****************
	// Tasks
	// ****************
	task automatic final_report;
		if (failures == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	function automatic logic sig(input int k);
		return (k == 0) ? cpu_run : (k == 1) ? cpu_start : bus_reset_irq;
	endfunction

	// Bounded wait; n holds the edges it took
	task automatic wait_for(input int k, input logic v, input int lim);
		n = 0;
		while (sig(k) !== v && n < lim) begin
			@(posedge clk_sys);
			#1 n++;
		end
		`CHK("wait", v, sig(k))
	endtask

	// Called in the first run cycle
	task automatic start_chk;
		`CHK("blk_start", 1'b1, stack_wr_block)
		`CHK("pc", 14'h0000, pc_init)
		`CHK("psp", 8'h00, psp_init)
		`CHK("dsp", 8'h00, dsp_init)
		@(posedge clk_sys);
		#1 `CHK("start_len", 1'b0, cpu_start)
		`CHK("blk_run", 1'b0, stack_wr_block)
		`CHK("srst_run", 1'b1, sys_rst_n)
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == LIMIT) begin
			failures++;
			final_report();
		end
	end

	// ****************
	// Sequence
	// ****************
	initial begin
		{nrst, supply_ok_pin, osc_stable_pin, gie_on, wr, rd, bus_reset_req} = '0;
		addr     = 8'h00;
		wdata    = 8'h00;
		ack_dly  = 4'h3;
		failures = 0;
		checks   = 0;
		repeat (12) @(posedge clk_sys);
		`CHK("run_rst", 1'b0, cpu_run)
		`CHK("srst_rst", 1'b0, sys_rst_n)
		`CHK("uadr_rst", 8'h00, usb_dev_addr)
		nrst           <= 1'b1;
		supply_ok_pin  <= 1'b1;
		osc_stable_pin <= 1'b1;
		wait_for(1, 1'b1, 2500);
		`CHK("por_len", 1'b1, n >= 96 * T && n <= 96 * (T + 2) + 8)
		start_chk();
		foreach (rows[i]) begin
			if (rows[i].w) begin
				reg_wr(rows[i].a, rows[i].v);
			end else begin
				reg_rd(rows[i].a, d);
				`CHK("row", rows[i].v, d)
			end
		end
		`CHK("irq_idle", 1'b0, bus_reset_irq)
		// Kicks spaced under the rollover keep the CPU running
		repeat (3) begin
			repeat (7 * T) @(posedge clk_sys);
			reg_wr(ADDR_WDT_RESTART, 8'h00);
			#1 `CHK("kick", 1'b1, cpu_run)
		end
		wait_for(0, 1'b0, 220);
		`CHK("wdt_len", 1'b1, n >= 8 * T && n <= 8 * (T + 2) + 4)
		`CHK("srst_wdr", 1'b0, sys_rst_n)
		`CHK("uadr_wdr", 8'h00, usb_dev_addr)
		wait_for(1, 1'b1, 100);
		`CHK("wdr_len", 1'b1, n >= 2 * T && n <= 2 * (T + 2) + 4)
		start_chk();
		reg_rd(ADDR_STATUS, d);
		`CHK("st_wdr", (8'h01 & STAT_WDR_KEEP) | STAT_WDR_SET, d)
		`CHK("cause_wdr", 1'b1, d[STAT_WDR_BIT] && !d[STAT_POR_BIT])
		reg_rd(ADDR_USB_ADDR, d);
		`CHK("uadr_clr", 8'h00, d)
		reg_rd(ADDR_INT_EN, d);
		`CHK("inten_clr", 8'h00, d)
		// Supply dip, then bus reset cuts the long wait short
		@(posedge clk_sys);
		supply_ok_pin <= 1'b0;
		wait_for(0, 1'b0, 8);
		repeat (5) @(posedge clk_sys);
		supply_ok_pin <= 1'b1;
		repeat (30 * (T + 2)) @(posedge clk_sys);
		`CHK("held", 1'b0, cpu_run)
		bus_reset_req <= 1'b1;
		wait_for(1, 1'b1, 8);
		start_chk();
		@(posedge clk_sys);
		bus_reset_req <= 1'b0;
		gie_on        <= 1'b1;
		repeat (20) @(posedge clk_sys);
		#1 `CHK("irq_masked", 1'b0, bus_reset_irq)
		reg_rd(ADDR_STATUS, d);
		`CHK("st_por", STAT_POR_VALUE, d)
		`CHK("cause_por", 1'b1, d[STAT_POR_BIT])
		reg_wr(ADDR_INT_EN, 8'h01);
		wait_for(2, 1'b1, 4);
		wait_for(2, 1'b0, 12);
		final_report();
	end
endmodule
